/* hdl/adcs_defs.vh */
// constants for the adc conversion sequencer
`ifndef ADCS_DEFS_VH
`define ADCS_DEFS_VH
// ====================================================
// register byte addresses
`define ADCS_CTL0_ADDR   8'h00
`define ADCS_CTL1_ADDR   8'h04
`define ADCS_DATAH_ADDR  8'h08
`define ADCS_DATAL_ADDR  8'h0C
`define ADCS_STAT_ADDR   8'h10
`define ADCS_ADDR_W      8
// ====================================================
// control 0 fields
`define ADCS_GO_BIT      7
`define ADCS_REFLO_BIT   6
`define ADCS_DRVOUT_BIT  5
`define ADCS_REP_BIT     4
`define ADCS_CHAN_MSB    3
`define ADCS_CTL0_RST    8'h00
// control 1 fields
`define ADCS_REFHI_BIT   7
`define ADCS_ENA_BIT     3
`define ADCS_MODE_MSB    2
`define ADCS_CTL1_RST    8'h88
// channel code that shorts the differential pair
`define ADCS_CAL_CHAN    4'hF
// ====================================================
// timing counts in system clock cycles
`define ADCS_IDLE_CYC    160
`define ADCS_PWRUP_CYC   40
`define ADCS_CONV_CYC    5129
`define ADCS_REP_CYC     256
`define ADCS_CNT_W       13
`define ADCS_RESP_OKAY   2'b00
`define ADCS_RESP_SLVERR 2'b10
`endif

/* hdl/adcs_idle_timer.v */
// idle counter that powers down the analog core
`timescale 1ns/1ps
`include "adcs_defs.vh"
module adcs_idle_timer #(
   parameter IDLE_CYC = `ADCS_IDLE_CYC
) (
   input  wire aclk,     // system clock
   input  wire aresetn,  // sync reset, active low
   input  wire busy,     // conversion running or requested
   input  wire start,    // power-up has just finished
   output reg  powered   // analog core is powered
);
   // last idle count before the core drops; 8 bits hold it
   localparam [31:0] IDLE_LAST = IDLE_CYC - 1;
   reg [7:0] idle_cnt;
   // ====================================================
   // count idle cycles; any start restarts the count
   always @(posedge aclk) begin
      if (!aresetn) begin
         idle_cnt <= 8'h00;
         powered  <= 1'b0;
      end else if (busy || start) begin
         idle_cnt <= 8'h00;
         if (start)
            powered <= 1'b1;
      end else if (powered) begin
         if (idle_cnt == IDLE_LAST[7:0]) begin
            powered  <= 1'b0;
            idle_cnt <= 8'h00;
         end else begin
            idle_cnt <= idle_cnt + 8'h01;
         end
      end
   end
endmodule

/* hdl/adcs_result_fmt.v */
// formats the raw sample into two result bytes
`timescale 1ns/1ps
module adcs_result_fmt (
   input  wire [12:0] sample,     // raw two's complement result
   input  wire        over,       // modulator over range
   output wire [7:0]  upper_byte, // result bits 12..5
   output wire [7:0]  lower_byte  // result 4..0, flag at bit 0
);
   // ====================================================
   // pack result; flag sits in bit 0 of the lower byte
   assign upper_byte = sample[12:5];
   assign lower_byte = {sample[4:0], 2'b00, over};
endmodule

/* hdl/adcs_seq.v */
// top of the adc conversion sequencer with axi4-lite slave
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "adcs_defs.vh"
module adcs_seq #(
   parameter CONV_CYC  = `ADCS_CONV_CYC,
   parameter PWRUP_CYC = `ADCS_PWRUP_CYC,
   parameter REP_CYC   = `ADCS_REP_CYC
) (
   input  wire        aclk,          // system clock 250 MHz
   input  wire        aresetn,       // sync reset, active low
   input  wire [7:0]  s_axi_awaddr,  // write address
   input  wire        s_axi_awvalid, // write address valid
   output reg         s_axi_awready, // write address ready
   input  wire [31:0] s_axi_wdata,   // write data
   input  wire [3:0]  s_axi_wstrb,   // write strobes
   input  wire        s_axi_wvalid,  // write data valid
   output reg         s_axi_wready,  // write data ready
   output reg  [1:0]  s_axi_bresp,   // write response
   output reg         s_axi_bvalid,  // write response valid
   input  wire        s_axi_bready,  // write response ready
   input  wire [7:0]  s_axi_araddr,  // read address
   input  wire        s_axi_arvalid, // read address valid
   output reg         s_axi_arready, // read address ready
   output reg  [31:0] s_axi_rdata,   // read data
   output reg  [1:0]  s_axi_rresp,   // read response
   output reg         s_axi_rvalid,  // read data valid
   input  wire        s_axi_rready,  // read data ready
   input  wire [12:0] mod_sample,    // modulator filter output
   input  wire        mod_over,      // modulator beyond reference
   output reg         conv_done_irq, // completion request pulse
   output reg         core_powered,  // analog core powered
   output reg         input_short,   // short differential pair
   output reg  [3:0]  input_channel_select, // analog mux select
   output reg  [2:0]  input_mode_select,    // buffer/diff mode
   output reg  [1:0]  ref_level,     // {upper, lower} ref bits
   output reg         ref_drive_out  // drive reference to pin
);
   localparam ST_IDLE  = 2'd0;
   localparam ST_PWRUP = 2'd1;
   localparam ST_CONV  = 2'd2;
   localparam ST_REP   = 2'd3;
   localparam [31:0] CONV_END   = CONV_CYC - 1;
   localparam [31:0] PWRUP_END  = PWRUP_CYC - 1;
   localparam [31:0] REP_END    = REP_CYC - 1;
   // the counter compares on 13 bits; every count fits
   localparam [12:0] CONV_LAST  = CONV_END[12:0];
   localparam [12:0] PWRUP_LAST = PWRUP_END[12:0];
   localparam [12:0] REP_LAST   = REP_END[12:0];

   reg  [7:0]  ctl0;
   reg  [7:0]  ctl1;
   reg  [7:0]  result_upper_byte;
   reg  [7:0]  result_lower_byte;
   reg  [1:0]  state;
   reg  [12:0] cnt;
   reg         have_aw;
   reg         have_w;
   reg  [7:0]  aw_addr;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   reg  [12:0] smp_s1;
   reg  [12:0] smp_s2;
   reg         ovr_s1;
   reg         ovr_s2;
   reg  [13:0] word_s3;
   reg  [13:0] word_hold;
   wire        idle_powered;
   wire [7:0]  fmt_upper;
   wire [7:0]  fmt_lower;
   wire        wr_fire;
   wire        go_write;
   wire        conv_enabled;
   wire        busy;
   wire        pwrup_done;

   // ====================================================
   // pin inputs from the analog side pass two flops
   always @(posedge aclk) begin
      if (!aresetn) begin
         smp_s1 <= 13'h0000;
         smp_s2 <= 13'h0000;
         ovr_s1 <= 1'b0;
         ovr_s2 <= 1'b0;
      end else begin
         smp_s1 <= mod_sample;
         smp_s2 <= smp_s1;
         ovr_s1 <= mod_over;
         ovr_s2 <= ovr_s1;
      end
   end

   // ====================================================
   // a word caught mid-change differs between stages and is
   // skipped, so the result never mixes two samples
   always @(posedge aclk) begin
      if (!aresetn) begin
         word_s3   <= 14'h0000;
         word_hold <= 14'h0000;
      end else begin
         word_s3 <= {ovr_s2, smp_s2};
         if (word_s3 == {ovr_s2, smp_s2})
            word_hold <= word_s3;
      end
   end

   adcs_result_fmt u_fmt (
      .sample     (word_hold[12:0]),
      .over       (word_hold[13]),
      .upper_byte (fmt_upper),
      .lower_byte (fmt_lower)
   );

   // ====================================================
   // axi4-lite write: address and data in either order
   assign wr_fire  = have_aw && have_w && !s_axi_bvalid;
   assign go_write = wr_fire && (aw_addr == `ADCS_CTL0_ADDR) &&
                     w_strb[0] && w_data[`ADCS_GO_BIT];
   assign conv_enabled = ctl1[`ADCS_ENA_BIT];
   assign busy = (state != ST_IDLE);
   assign pwrup_done = (state == ST_PWRUP) && (cnt == PWRUP_LAST);

   always @(posedge aclk) begin
      if (!aresetn) begin
         have_aw       <= 1'b0;
         have_w        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `ADCS_RESP_OKAY;
      end else begin
         s_axi_awready <= !have_aw && !s_axi_awready;
         s_axi_wready  <= !have_w && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            have_aw <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            have_w <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            have_aw      <= 1'b0;
            have_w       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // only the two control registers take writes
            if (aw_addr == `ADCS_CTL0_ADDR ||
                aw_addr == `ADCS_CTL1_ADDR)
               s_axi_bresp <= `ADCS_RESP_OKAY;
            else
               s_axi_bresp <= `ADCS_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ====================================================
   // control registers; hardware clear of go loses to a set
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctl0 <= `ADCS_CTL0_RST;
         ctl1 <= `ADCS_CTL1_RST;
      end else begin
         if (state == ST_CONV && cnt == CONV_LAST)
            ctl0[`ADCS_GO_BIT] <= 1'b0;
         // an abort by disable ends the conversion too
         if (!conv_enabled && busy)
            ctl0[`ADCS_GO_BIT] <= 1'b0;
         if (wr_fire && w_strb[0]) begin
            if (aw_addr == `ADCS_CTL0_ADDR) begin
               // all fields in one write; go only sets
               ctl0[6:0] <= w_data[6:0];
               if (w_data[`ADCS_GO_BIT])
                  ctl0[`ADCS_GO_BIT] <= 1'b1;
            end else if (aw_addr == `ADCS_CTL1_ADDR) begin
               ctl1 <= w_data[7:0];
            end
         end
      end
   end

   // ====================================================
   // idle power-down count, restarted on every start; a go
   // write counts as busy so a start never races the drop
   adcs_idle_timer #(
      .IDLE_CYC (`ADCS_IDLE_CYC)
   ) u_idle (
      .aclk    (aclk),
      .aresetn (aresetn),
      .busy    (busy || go_write),
      .start   (pwrup_done),
      .powered (idle_powered)
   );

   // ====================================================
   // sequencer: power-up, first conversion, repeats
   always @(posedge aclk) begin
      if (!aresetn) begin
         state             <= ST_IDLE;
         cnt               <= 13'h0000;
         conv_done_irq     <= 1'b0;
         result_upper_byte <= 8'h00;
         result_lower_byte <= 8'h00;
      end else begin
         conv_done_irq <= 1'b0;
         if (go_write && conv_enabled) begin
            // a new go restarts any running conversion
            cnt <= 13'h0000;
            if (idle_powered)
               state <= ST_CONV;
            else
               state <= ST_PWRUP;
         end else if (!conv_enabled) begin
            state <= ST_IDLE;
            cnt   <= 13'h0000;
         end else begin
            case (state)
               ST_PWRUP: begin
                  if (cnt == PWRUP_LAST) begin
                     state <= ST_CONV;
                     cnt   <= 13'h0000;
                  end else begin
                     cnt <= cnt + 13'h0001;
                  end
               end
               ST_CONV, ST_REP: begin
                  if (state == ST_REP && !ctl0[`ADCS_REP_BIT]) begin
                     // repeat cleared: stop, no further result
                     state <= ST_IDLE;
                     cnt   <= 13'h0000;
                  end else if ((state == ST_CONV && cnt == CONV_LAST) ||
                      (state == ST_REP && cnt == REP_LAST)) begin
                     // data change only at completion
                     result_upper_byte <= fmt_upper;
                     result_lower_byte <= fmt_lower;
                     conv_done_irq     <= 1'b1;
                     cnt <= 13'h0000;
                     if (ctl0[`ADCS_REP_BIT])
                        state <= ST_REP;
                     else
                        state <= ST_IDLE;
                  end else begin
                     cnt <= cnt + 13'h0001;
                  end
               end
               default: begin
                  cnt <= 13'h0000;
               end
            endcase
         end
      end
   end

   // ====================================================
   // registered analog controls
   always @(posedge aclk) begin
      if (!aresetn) begin
         core_powered         <= 1'b0;
         input_short          <= 1'b0;
         input_channel_select <= 4'h0;
         input_mode_select    <= 3'h0;
         ref_level            <= 2'b10;
         ref_drive_out        <= 1'b0;
      end else begin
         core_powered <= idle_powered || busy;
         input_short  <= (ctl0[`ADCS_CHAN_MSB:0] ==
                          `ADCS_CAL_CHAN);
         input_channel_select <= ctl0[`ADCS_CHAN_MSB:0];
         input_mode_select    <= ctl1[`ADCS_MODE_MSB:0];
         // 11 is reserved; pass as written
         ref_level <= {ctl1[`ADCS_REFHI_BIT],
                       ctl0[`ADCS_REFLO_BIT]};
         // software must enable the internal
         ref_drive_out <= ctl0[`ADCS_DRVOUT_BIT];
      end
   end

   // ====================================================
   // axi4-lite read, one cycle answer after the address
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `ADCS_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready &&
                          s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `ADCS_RESP_OKAY;
            if (s_axi_araddr == `ADCS_CTL0_ADDR)
               s_axi_rdata <= {24'h00_0000, ctl0};
            else if (s_axi_araddr == `ADCS_CTL1_ADDR)
               s_axi_rdata <= {24'h00_0000, ctl1};
            else if (s_axi_araddr == `ADCS_DATAH_ADDR)
               s_axi_rdata <= {24'h00_0000, result_upper_byte};
            else if (s_axi_araddr == `ADCS_DATAL_ADDR)
               s_axi_rdata <= {24'h00_0000, result_lower_byte};
            else if (s_axi_araddr == `ADCS_STAT_ADDR)
               s_axi_rdata <= {28'h000_0000, idle_powered,
                               1'b0, state};
            else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `ADCS_RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

/* dv/adcs_seq_props.sv */
// concurrent checks on the adc conversion sequencer ports
`timescale 1ns/1ps
module adcs_seq_chk #(
   parameter REP_CYC = 256
) (
   input wire       aclk,                 // clock
   input wire       aresetn,              // sync reset, low
   input wire       s_axi_arvalid,        // read address valid
   input wire       s_axi_arready,        // read address ready
   input wire       s_axi_rvalid,         // read data valid
   input wire       conv_done_irq,        // completion pulse
   input wire       core_powered,         // core powered
   input wire       input_short,          // pair shorted
   input wire [3:0] input_channel_select, // mux select
   input wire [1:0] ref_level             // reference pair
);
   // ======================================
   // cycles since the last completion, saturating; starts high
   // so the first pulse after reset is never judged too early
   reg [15:0] gap;
   always @(posedge aclk) begin
      if (!aresetn)
         gap <= 16'hFFFF;
      else if (conv_done_irq)
         gap <= 16'h0001;
      else if (gap != 16'hFFFF)
         gap <= gap + 16'h0001;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_irq_pulse: assert property (
      conv_done_irq |=> !conv_done_irq)
      else $error("completion pulse wider than one cycle");
   chk_irq_spacing: assert property (
      conv_done_irq |-> gap >= REP_CYC)
      else $error("completions closer than the repeat period");
   chk_idle_off: assert property (
      $fell(core_powered) |-> gap >= 160)
      else $error("core powered down before the idle count");
   chk_irq_power: assert property (
      conv_done_irq |-> core_powered)
      else $error("completion while the core is unpowered");
   chk_power_hold: assert property (
      conv_done_irq |=> core_powered [*8])
      else $error("core dropped right after a completion");
   chk_short_cal: assert property (
      input_short == (input_channel_select == 4'hF))
      else $error("pair short does not follow the channel");
   chk_ref_reset: assert property (
      $rose(aresetn) |-> ref_level == 2'h2)
      else $error("reference pair not at its default");
   chk_rd_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   cover property (conv_done_irq && gap == REP_CYC);
   cover property ($fell(core_powered));
   cover property (conv_done_irq && input_short);
endmodule
bind adcs_seq adcs_seq_chk #(.REP_CYC(REP_CYC)) u_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .conv_done_irq(conv_done_irq), .core_powered(core_powered),
   .input_short(input_short),
   .input_channel_select(input_channel_select), .ref_level(ref_level));

/* dv/adcs_mod_model.sv */
// modulator model standing behind the converter's analog pins
`timescale 1ns/1ps
module adcs_mod_model #(
   parameter OFFSET = 13'h0015 // arbitrary converter offset
) (
   input  wire        aclk,       // system clock
   input  wire [12:0] level,      // sample the bench asks for
   input  wire        beyond,     // bench asks for over-range
   input  wire        shorted,    // calibration switch closed
   output reg  [12:0] mod_sample, // filtered sample
   output reg         mod_over    // beyond the reference
);
   // ======================================
   // shorted inputs leave only the offset, never an over-range
   always @(posedge aclk) begin
      mod_sample <= shorted ? OFFSET : level;
      mod_over   <= shorted ? 1'h0 : beyond;
   end
endmodule

/* dv/adcs_seq_tb.sv */
// self-checking bench for the adc conversion sequencer
`timescale 1ns/1ps
`include "adcs_defs.vh"
`define CHK(g, e) begin \
   checked++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); \
   end \
end
module adcs_seq_tb;
   localparam CONV = 50;
   localparam PWR  = 8;
   localparam REP  = 16;
   localparam [12:0] OFF = 13'h0015; // arbitrary offset
   localparam integer GAIN = 32'h0000_4000; // arbitrary gain trim
   reg         aclk, aresetn, awvalid, wvalid, arvalid, beyond;
   reg  [7:0]  awaddr, araddr;
   reg  [31:0] wdata;
   reg  [12:0] level, raw;
   reg  [2:0]  i;
   wire        awready, wready, bvalid, arready, rvalid, over;
   wire        irq, powered, short, drv;
   wire [1:0]  bresp, rresp, ref_lvl;
   wire [31:0] rdata;
   wire [12:0] sample;
   wire [3:0]  chan;
   wire [2:0]  mode;
   integer     failures, checked, cyc_n, nirq, t0, n, n0, comp;
   // ======================================
   adcs_seq #(.CONV_CYC(CONV), .PWRUP_CYC(PWR), .REP_CYC(REP)) dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
      .mod_sample(sample), .mod_over(over), .conv_done_irq(irq),
      .core_powered(powered), .input_short(short),
      .input_channel_select(chan), .input_mode_select(mode),
      .ref_level(ref_lvl), .ref_drive_out(drv));
   adcs_mod_model #(.OFFSET(OFF)) u_mod (
      .aclk(aclk), .level(level), .beyond(beyond), .shorted(short),
      .mod_sample(sample), .mod_over(over));
   always #2 aclk = ~aclk;
   // cycle stamp, completion count and hang guard
   always @(posedge aclk) begin
      cyc_n <= cyc_n + 1;
      if (irq)
         nirq <= nirq + 1;
      if (cyc_n == 5000) begin
         failures++;
         close_out;
      end
   end
   task close_out;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ready lines stay high, so only valids need releasing
   task automatic wr(input [7:0] a, input [7:0] d);
      awaddr  <= a;
      wdata   <= {24'h00_0000, d};
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      `CHK(bresp, 2'h0)
      @(posedge aclk);
   endtask
   task automatic rdc(input [7:0] a, input [7:0] e, input [1:0] r = 2'h0);
      araddr  <= a;
      arvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      `CHK(rdata, {24'h00_0000, e})
      `CHK(rresp, r)
   endtask
   task automatic chkdata(input [12:0] s, input o);
      rdc(`ADCS_DATAH_ADDR, s[12:5]);
      raw[12:5] = rdata[7:0];
      rdc(`ADCS_DATAL_ADDR, {s[4:0], 2'h0, o});
      raw[4:0] = rdata[7:3];
   endtask
   task automatic wirq;
      do
         @(posedge aclk);
      while (irq !== 1'h1);
      n = cyc_n - t0;
   endtask
   // start-to-done counts carry a few cycles of bus latency
   function automatic bit near(input integer g, input integer e);
      near = g >= e - 3 && g <= e + 3;
   endfunction
   initial begin
      {aclk, aresetn, awvalid, wvalid, arvalid, beyond} = 6'h00;
      {awaddr, araddr, wdata} = 48'h0000_0000_0000;
      level = 13'h1A5B;
      {failures, checked, cyc_n, nirq} = 128'h0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rdc(`ADCS_CTL0_ADDR, 8'h00);
      rdc(`ADCS_CTL1_ADDR, 8'h88);
      rdc(8'h14, 8'h00, 2'h2);
      rdc(`ADCS_STAT_ADDR, 8'h00);
      `CHK(ref_lvl, 2'h2)
      `CHK(powered, 1'h0)
      $display("reset values done");
      wr(`ADCS_CTL0_ADDR, 8'h83);
      t0 = cyc_n;
      `CHK(chan, 4'h3)
      rdc(`ADCS_CTL0_ADDR, 8'h83);
      wirq;
      `CHK(near(n, PWR + CONV), 1'h1)
      rdc(`ADCS_CTL0_ADDR, 8'h03);
      chkdata(13'h1A5B, 1'h0);
      n0 = nirq;
      repeat (CONV + 20) @(posedge aclk);
      `CHK(nirq, n0)
      $display("single shot done");
      wr(`ADCS_CTL0_ADDR, 8'h83);
      repeat (10) @(posedge aclk);
      wr(`ADCS_CTL0_ADDR, 8'h03);
      rdc(`ADCS_CTL0_ADDR, 8'h83);
      wr(`ADCS_CTL0_ADDR, 8'h83);
      t0 = cyc_n;
      wirq;
      `CHK(near(n, CONV), 1'h1)
      $display("restart done");
      level <= 13'h0F0F;
      beyond <= 1'h1;
      wr(`ADCS_CTL0_ADDR, 8'h93);
      t0 = cyc_n;
      wirq;
      `CHK(near(n, CONV), 1'h1)
      t0 = cyc_n;
      wirq;
      `CHK(n, REP)
      rdc(`ADCS_CTL0_ADDR, 8'h13);
      chkdata(13'h0F0F, 1'h1);
      level <= 13'h10A4;
      beyond <= 1'h0;
      wirq;
      wirq;
      chkdata(13'h10A4, 1'h0);
      wr(`ADCS_CTL0_ADDR, 8'h03);
      n0 = nirq;
      repeat (3 * REP) @(posedge aclk);
      `CHK(nirq, n0)
      repeat (140 - 3 * REP) @(posedge aclk);
      `CHK(powered, 1'h1)
      repeat (30) @(posedge aclk);
      `CHK(powered, 1'h0)
      $display("continuous and idle done");
      wr(`ADCS_CTL0_ADDR, 8'h83);
      repeat (PWR + 5) @(posedge aclk);
      `CHK(powered, 1'h1)
      wr(`ADCS_CTL1_ADDR, 8'h80);
      n0 = nirq;
      repeat (PWR + CONV + 20) @(posedge aclk);
      `CHK(nirq, n0)
      $display("disable done");
      // drive-out only with an internal reference chosen
      for (i = 0; i < 4; i++) begin
         wr(`ADCS_CTL1_ADDR, {i[1], 4'h1, i + 3'h3});
         wr(`ADCS_CTL0_ADDR, {1'h0, i[0], i != 0, 1'h0, 4'hC + i});
         `CHK(ref_lvl, i[1:0])
         `CHK(mode, i + 3'h3)
         `CHK(drv, i != 0)
         `CHK(short, i == 3)
      end
      wr(`ADCS_CTL0_ADDR, 8'h8F);
      wirq;
      chkdata(OFF, 1'h0);
      // software trim: offset first, multiply before the divide
      comp = raw - (OFF - 13'h0004);
      comp = comp + comp * GAIN / 32'h0001_0000;
      `CHK(comp, 32'h0000_0005)
      $display("configuration done");
      close_out;
   end
endmodule
